// ### rtl/tig_pkg.sv
// constants, register map and state type of the touch interrupt and pin block
package tig_pkg;
    // register offsets
    localparam logic [15:0] TIG_OFS_PIN_CFG  = 16'h0009;
    localparam logic [15:0] TIG_OFS_IRQ      = 16'h0043;
    localparam logic [15:0] TIG_OFS_LOC      = 16'h0045;
    localparam logic [15:0] TIG_OFS_ASSIGN   = 16'h0074;
    // reset values
    localparam logic [15:0] TIG_PIN_CFG_RST  = 16'h0002;
    localparam logic [15:0] TIG_ASSIGN_RST   = 16'h0000;
    // writable bits
    localparam logic [15:0] TIG_PIN_CFG_MASK = 16'h001f;
    localparam logic [15:0] TIG_ASSIGN_MASK  = 16'h01ff;
    // field positions
    localparam int          TIG_MODE_LSB     = 0;
    localparam int          TIG_MODE_W       = 2;
    localparam int          TIG_TRIG_LSB     = 2;
    localparam int          TIG_TRIG_W       = 3;
    localparam int          TIG_IRQ_GPIO_BIT = 15;
    localparam int          TIG_IRQ_SLD_BIT  = 8;
    localparam int          TIG_LOC_DIR_BIT  = 8;
    localparam int          TIG_LOC_W        = 5;
    localparam int          TIG_WHEEL_BIT    = 8;
    // pin modes
    localparam logic [1:0]  TIG_MODE_OFF     = 2'h0;
    localparam logic [1:0]  TIG_MODE_IN      = 2'h1;
    localparam logic [1:0]  TIG_MODE_LOW     = 2'h2;
    localparam logic [1:0]  TIG_MODE_HIGH    = 2'h3;
    // input trigger selections
    localparam logic [2:0]  TIG_TRIG_LOW     = 3'h1;
    localparam logic [2:0]  TIG_TRIG_HIGH    = 3'h2;
    localparam logic [2:0]  TIG_TRIG_FALL    = 3'h5;
    localparam logic [2:0]  TIG_TRIG_RISE    = 3'h6;
    localparam logic [2:0]  TIG_TRIG_BOTH    = 3'h7;
    // serial port
    localparam logic [2:0]  TIG_LAST_BIT     = 3'h7;
    localparam logic [6:0]  TIG_DEV_ADDR_DEF = 7'h2c;
    localparam logic [1:0]  TIG_OFS_LO_IDX   = 2'h1;
    localparam logic [1:0]  TIG_DATA_IDX     = 2'h3;
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK
    } tig_ser_st_t;
endpackage : tig_pkg

// ### rtl/tig_top.sv
// touch status, interrupt pin, slider location, pin control and serial register port
`timescale 1ns/1ps
module tig_top #(
    parameter logic [6:0] DEV_ADDR = tig_pkg::TIG_DEV_ADDR_DEF, // arbitrary value
    parameter int         N_CH     = 8
) (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    // power-up polarity strap
    input  wire logic                          irq_invert,
    // touch engine events
    input  wire logic [N_CH-1:0]               touch_down,
    input  wire logic [N_CH-1:0]               touch_up,
    input  wire logic                          slider_valid,
    input  wire logic [2:0]                    slider_elem,
    input  wire logic                          slider_half,
    input  wire logic                          slider_dir,
    // guard drive
    input  wire logic [N_CH-1:0]               sense_excite,
    input  wire logic [2:0]                    sense_sel,
    output logic                               guard_out,
    // interrupt pin
    output logic                               irq_out_n,
    // general-purpose pin
    input  wire logic                          gpio_in,
    output logic                               gpio_out,
    output logic                               gpio_oe,
    // serial port
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe
);
    import tig_pkg::*;

    function automatic logic [4:0] pop8(input logic [7:0] v);
        pop8 = 5'h0;
        for (int i = 0; i < 8; i++) begin
            pop8 = pop8 + {4'h0, v[i]};
        end
    endfunction : pop8

    logic [15:0]       pin_cfg_r;
    logic [15:0]       assign_r;
    logic [N_CH-1:0]   sensor_r;
    logic              touch_pend_r;
    logic              slider_flag_r;
    logic              gpio_flag_r;
    logic [4:0]        loc_r;
    logic              dir_r;
    logic              inv_r;
    logic              cap_done_r;
    logic              gpio_q_r;
    logic              clr_pulse;
    logic              gpio_cond;
    logic              gpio_trig;
    logic              irq_act;
    logic [1:0]        mode;
    logic [2:0]        trig;
    logic [15:0]       irq_val;
    logic [15:0]       rd_val;
    logic [4:0]        n_elem;
    logic [4:0]        pos_raw;
    logic [4:0]        pos_nxt;
    logic [7:0]        sh_r, wbuf_r;
    logic [15:0]       ofs_r, txd_r;
    logic [2:0]        bit_r;
    logic [1:0]        byte_idx_r;
    tig_ser_st_t       st_r;
    logic              scl_q_r, sda_q_r, scl_rise, scl_fall, start_det, stop_det;
    logic              full_r, rw_r, rd_irq_r, ack_ok, wr_en;

    assign mode    = pin_cfg_r[TIG_MODE_LSB +: TIG_MODE_W];
    assign trig    = pin_cfg_r[TIG_TRIG_LSB +: TIG_TRIG_W];
    assign irq_act = touch_pend_r | slider_flag_r | gpio_flag_r;

    ////////////////////////////////////////////////////////////////////////////
    // polarity strap caught once after reset release
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            inv_r      <= 1'b0;
            cap_done_r <= 1'b0;
        end else if (!cap_done_r) begin
            inv_r      <= irq_invert;
            cap_done_r <= 1'b1;
        end
    end

    // per-sensor touch state, down wins on a tie
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sensor_r <= '0;
        end else begin
            sensor_r <= (sensor_r & ~touch_up) | touch_down;
        end
    end

    // pending touch event, new event beats the read clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            touch_pend_r <= 1'b0;
        end else if (|touch_down || |touch_up) begin
            touch_pend_r <= 1'b1;
        end else if (clr_pulse) begin
            touch_pend_r <= 1'b0;
        end
    end

    // slider location with two-times interpolation
    always_comb begin
        n_elem  = pop8(assign_r[7:0]);
        pos_raw = {1'b0, slider_elem, slider_half};
        pos_nxt = pos_raw;
        if (assign_r[TIG_WHEEL_BIT]) begin
            if (pos_raw >= {n_elem[3:0], 1'b0}) pos_nxt = pos_raw - {n_elem[3:0], 1'b0};
        end else if (n_elem != 5'h0 && pos_raw > {n_elem[3:0], 1'b0} - 5'h2) begin
            pos_nxt = {n_elem[3:0], 1'b0} - 5'h2;
        end
    end

    // slider flag, location and direction
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slider_flag_r <= 1'b0;
            loc_r         <= '0;
            dir_r         <= 1'b0;
        end else if (slider_valid && |assign_r[7:0]) begin
            slider_flag_r <= 1'b1;
            loc_r         <= pos_nxt;
            dir_r         <= slider_dir;
        end else if (clr_pulse) begin
            slider_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin trigger decode
    always_comb begin
        gpio_cond = 1'b0;
        gpio_trig = 1'b0;
        if (mode == TIG_MODE_IN) begin
            case (trig)
                TIG_TRIG_LOW:  gpio_cond = !gpio_in;
                TIG_TRIG_HIGH: gpio_cond = gpio_in;
                TIG_TRIG_FALL: gpio_trig = gpio_q_r && !gpio_in;
                TIG_TRIG_RISE: gpio_trig = !gpio_q_r && gpio_in;
                TIG_TRIG_BOTH: gpio_trig = gpio_q_r != gpio_in;
                default:       gpio_trig = 1'b0;
            endcase
        end
        gpio_trig = gpio_trig | gpio_cond;
    end

    // pin flag held while a level condition persists
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gpio_flag_r <= 1'b0;
            gpio_q_r    <= 1'b0;
        end else begin
            gpio_q_r <= gpio_in;
            if (gpio_trig) begin
                gpio_flag_r <= 1'b1;
            end else if (clr_pulse) begin
                gpio_flag_r <= 1'b0;
            end
        end
    end

    // pin drive, guard and interrupt outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gpio_oe   <= 1'b1;
            gpio_out  <= 1'b0;
            guard_out <= 1'b0;
            irq_out_n <= 1'b1;
        end else begin
            gpio_oe   <= mode == TIG_MODE_LOW || mode == TIG_MODE_HIGH;
            gpio_out  <= mode == TIG_MODE_HIGH;
            guard_out <= sense_excite[sense_sel];
            irq_out_n <= inv_r ? irq_act : !irq_act;
        end
    end

    assign irq_val = {gpio_flag_r, 6'h0, slider_flag_r, sensor_r};

    // register read mux, unmapped reads zero
    always_comb begin
        case (ofs_r)
            TIG_OFS_PIN_CFG: rd_val = pin_cfg_r;
            TIG_OFS_IRQ:     rd_val = irq_val;
            TIG_OFS_LOC:     rd_val = {7'h0, dir_r, 3'h0, loc_r};
            TIG_OFS_ASSIGN:  rd_val = assign_r;
            default:         rd_val = '0;
        endcase
    end
    // serial line history and edges, idle high so reset shows no false edge
    always_ff @(posedge ref_clk) begin
        scl_q_r <= rst ? 1'b1 : scl_in;
        sda_q_r <= rst ? 1'b1 : sda_in;
    end
    assign scl_rise  = scl_in && !scl_q_r;
    assign scl_fall  = !scl_in && scl_q_r;
    assign start_det = scl_in && scl_q_r && sda_q_r && !sda_in;
    assign stop_det  = scl_in && scl_q_r && !sda_q_r && sda_in;
    assign clr_pulse = stop_det && rd_irq_r;
    assign ack_ok    = st_r == S_RX || sh_r[7:1] == DEV_ADDR;
    assign wr_en     = st_r == S_RX && scl_fall && full_r && byte_idx_r == TIG_DATA_IDX;
    // serial slave: shift on scl rise, drive sda after scl fall
    always_ff @(posedge ref_clk) begin
        if (rst || start_det || stop_det) begin
            st_r       <= start_det && !rst ? S_ADDR : S_IDLE;
            bit_r      <= '0;
            full_r     <= 1'b0;
            byte_idx_r <= '0;
            rd_irq_r   <= 1'b0;
            sda_oe     <= 1'b0;
        end else begin
            case (st_r)
                S_ADDR, S_RX: begin
                    if (scl_rise) begin
                        sh_r   <= {sh_r[6:0], sda_in};
                        bit_r  <= bit_r + 3'h1;
                        full_r <= bit_r == TIG_LAST_BIT;
                    end else if (scl_fall && full_r) begin
                        full_r     <= 1'b0;
                        sda_oe     <= ack_ok;
                        sda_out    <= 1'b0;
                        st_r       <= ack_ok ? S_AACK : S_IDLE;
                        rw_r       <= st_r == S_ADDR && sh_r[0];
                        byte_idx_r <= st_r == S_RX && byte_idx_r != TIG_DATA_IDX ? byte_idx_r + 2'h1 : byte_idx_r;
                        ofs_r      <= st_r == S_RX && byte_idx_r == TIG_OFS_LO_IDX ? {wbuf_r, sh_r} : ofs_r;
                        wbuf_r     <= sh_r;
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        st_r     <= rw_r ? S_TX : S_RX;
                        txd_r    <= rd_val;
                        sda_oe   <= rw_r;
                        sda_out  <= rd_val[15];
                        rd_irq_r <= rw_r && ofs_r == TIG_OFS_IRQ;
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        txd_r   <= {txd_r[14:0], 1'b0};
                        sda_out <= txd_r[14];
                        bit_r   <= bit_r + 3'h1;
                        sda_oe  <= bit_r != TIG_LAST_BIT;
                        st_r    <= bit_r == TIG_LAST_BIT ? S_TACK : S_TX;
                    end
                end
                S_TACK: begin
                    if (scl_rise && sda_in) begin
                        st_r <= S_IDLE;
                    end else if (scl_fall) begin
                        st_r    <= S_TX;
                        sda_oe  <= 1'b1;
                        sda_out <= txd_r[15];
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end
    // register writes land at the ack of the second data byte
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_cfg_r <= TIG_PIN_CFG_RST;
            assign_r  <= TIG_ASSIGN_RST;
        end else if (wr_en) begin
            pin_cfg_r <= ofs_r == TIG_OFS_PIN_CFG ? {wbuf_r, sh_r} & TIG_PIN_CFG_MASK : pin_cfg_r;
            assign_r  <= ofs_r == TIG_OFS_ASSIGN ? {wbuf_r, sh_r} & TIG_ASSIGN_MASK : assign_r;
        end
    end
    // checks on the block's own state
    default clocking tig_cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_sensor_set: assert property (|touch_down |=> |(sensor_r & $past(touch_down))) else $error("no sensor bit");
    chk_touch_pend: assert property (|touch_down |=> touch_pend_r) else $error("touch not pending");
    chk_irq_level: assert property (cap_done_r |=> irq_out_n == ($past(inv_r) ^ !$past(irq_act))) else $error("irq lvl");
    chk_read_clear: assert property (clr_pulse && !gpio_trig |=> !gpio_flag_r) else $error("flag not cleared");
    chk_gpio_hold: assert property (gpio_trig |=> gpio_flag_r) else $error("pin flag lost");
    chk_pin_drive: assert property (1'b1 |=> gpio_oe == $past(mode == TIG_MODE_LOW || mode == TIG_MODE_HIGH)) else $error("oe");
endmodule : tig_top

// ### test/tig_host.sv
// host model: serial master reading and writing the block registers
`timescale 1ns/1ps
module tig_host (
    // clock
    input  wire logic ref_clk,
    // serial lines
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_line
);
    import tig_pkg::*;
    // bus idles released high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // quarter bit, changes land after the edge
    task automatic q;
        repeat (4) @(posedge ref_clk);
        #2;
    endtask : q
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b; q; scl = 1'b1; q; r = sda_line; q; scl = 1'b0; q;
    endtask : bit_io
    task automatic start;
        sda_drv = 1'b1; q; scl = 1'b1; q; sda_drv = 1'b0; q; scl = 1'b0; q;
    endtask : start
    task automatic wb(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], a);
        bit_io(1'b1, a);
    endtask : wb
    task automatic rb(input logic last, output logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, a);
    endtask : rb
    task automatic stop;
        sda_drv = 1'b0; q; scl = 1'b1; q; sda_drv = 1'b1; q;
    endtask : stop
    task automatic write_reg(input logic [15:0] ofs, input logic [15:0] d);
        start; wb({TIG_DEV_ADDR_DEF, 1'b0}); wb(ofs[15:8]); wb(ofs[7:0]);
        wb(d[15:8]); wb(d[7:0]); stop;
    endtask : write_reg
    // status read completes at the stop, which clears it
    task automatic read_reg(input logic [15:0] ofs, output logic [15:0] d);
        start; wb({TIG_DEV_ADDR_DEF, 1'b0}); wb(ofs[15:8]); wb(ofs[7:0]);
        start; wb({TIG_DEV_ADDR_DEF, 1'b1}); rb(1'b0, d[15:8]); rb(1'b1, d[7:0]); stop;
    endtask : read_reg
endmodule : tig_host

// ### test/testbench.sv
// self-checking bench of the touch interrupt and pin block
`timescale 1ns/1ps
module testbench;
    import tig_pkg::*;
    logic       ref_clk, rst, gpio_in, scl, sda_drv, guard_out, irq_out_n, gpio_out, gpio_oe, sda_out, sda_oe;
    logic [7:0] touch_down, touch_up, sense_excite;
    logic [2:0] sense_sel, slider_elem;
    logic       slider_valid, slider_half, slider_dir, irq_invert;
    logic [15:0] rd;
    int         miscompares, tests_run;
    wire logic  sda_line = sda_drv & ~(sda_oe & ~sda_out);
    ////////////////////////////////////////////////////////////////
    // clock and instances
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    tig_top dut_u (.ref_clk(ref_clk), .rst(rst), .irq_invert(irq_invert), .touch_down(touch_down),
        .touch_up(touch_up), .slider_valid(slider_valid), .slider_elem(slider_elem), .slider_half(slider_half),
        .slider_dir(slider_dir), .sense_excite(sense_excite), .sense_sel(sense_sel), .guard_out(guard_out),
        .irq_out_n(irq_out_n), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
    tig_host host_u (.ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
    ////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic give_verdict;
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : tick
    // bounded wait for the interrupt pin level
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq_out_n !== lvl && n < 4000) begin
            tick(1);
            n++;
        end
        chk({15'h0, irq_out_n}, {15'h0, lvl});
        if (n == 4000) give_verdict;
    endtask : wait_irq
    task automatic rd_chk(input logic [15:0] ofs, input logic [15:0] exp);
        host_u.read_reg(ofs, rd);
        chk(rd, exp);
    endtask : rd_chk
    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        chk({14'h0, gpio_oe, gpio_out}, 16'h0002);
        chk({15'h0, irq_out_n}, 16'h0001);
        rd_chk(TIG_OFS_PIN_CFG, 16'h0002);
    endtask : t_reset
    task automatic t_touch;
        touch_down[3] = 1'b1; tick(1); touch_down = '0;
        wait_irq(1'b0);
        rd_chk(TIG_OFS_IRQ, 16'h0008);
        wait_irq(1'b1);
        touch_up[3] = 1'b1; tick(1); touch_up = '0;
        wait_irq(1'b0);
        rd_chk(TIG_OFS_IRQ, 16'h0000);
        wait_irq(1'b1);
    endtask : t_touch
    task automatic t_pins;
        host_u.write_reg(TIG_OFS_PIN_CFG, 16'h0003); tick(4);
        chk({14'h0, gpio_oe, gpio_out}, 16'h0003);
        host_u.write_reg(TIG_OFS_PIN_CFG, 16'h0000); tick(4);
        chk({15'h0, gpio_oe}, 16'h0000);
        host_u.write_reg(TIG_OFS_ASSIGN, 16'h00ff);
        rd_chk(TIG_OFS_ASSIGN, 16'h00ff);
    endtask : t_pins
    task automatic t_gpio_in;
        host_u.write_reg(TIG_OFS_PIN_CFG, 16'h0019); gpio_in = 1'b1;
        wait_irq(1'b0);
        rd_chk(TIG_OFS_IRQ, 16'h8000);
        wait_irq(1'b1);
        host_u.write_reg(TIG_OFS_PIN_CFG, 16'h0015); gpio_in = 1'b0;
        wait_irq(1'b0);
        rd_chk(TIG_OFS_IRQ, 16'h8000);
        wait_irq(1'b1);
        host_u.write_reg(TIG_OFS_PIN_CFG, 16'h0009); gpio_in = 1'b1;
        wait_irq(1'b0);
        rd_chk(TIG_OFS_IRQ, 16'h8000);
        tick(40);
        chk({15'h0, irq_out_n}, 16'h0000);
        gpio_in = 1'b0;
        rd_chk(TIG_OFS_IRQ, 16'h8000);
        wait_irq(1'b1);
    endtask : t_gpio_in
    task automatic t_slider;
        slider_elem = 3'h7; slider_half = 1'b1; slider_dir = 1'b1;
        slider_valid = 1'b1; tick(1); slider_valid = 1'b0;
        wait_irq(1'b0);
        rd_chk(TIG_OFS_LOC, 16'h010e);
        rd_chk(TIG_OFS_IRQ, 16'h0100);
        wait_irq(1'b1);
    endtask : t_slider
    task automatic t_invert;
        rst = 1'b1; irq_invert = 1'b1; tick(3); rst = 1'b0; tick(3);
        chk({15'h0, irq_out_n}, 16'h0000);
        touch_down[1] = 1'b1; tick(1); touch_down = '0;
        wait_irq(1'b1);
        rd_chk(TIG_OFS_IRQ, 16'h0002);
        wait_irq(1'b0);
    endtask : t_invert
    task automatic t_guard;
        sense_sel = 3'h5; sense_excite = 8'h20; tick(3);
        chk({15'h0, guard_out}, 16'h0001);
        sense_excite = 8'hdf; tick(3);
        chk({15'h0, guard_out}, 16'h0000);
    endtask : t_guard
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        miscompares = 0; tests_run = 0; rst = 1'b1; gpio_in = 1'b0;
        touch_down = '0; touch_up = '0; sense_excite = '0; sense_sel = '0;
        slider_valid = 1'b0; slider_elem = '0; slider_half = 1'b0; slider_dir = 1'b0; irq_invert = 1'b0;
        tick(8); rst = 1'b0; tick(2);
        t_reset; t_touch; t_pins; t_gpio_in; t_slider; t_invert; t_guard;
        give_verdict;
    end
endmodule : testbench
